// ---- core/oca_config_a.sv ----
// Overview of operation
// - The precharge field picks the zero-volt FET, the charge FET, the alternate drive, or nothing.
// - The display runs in parallel mode when the interface bit is 0 and in serial mode when it is 1.
// - The temperature field picks internal, first thermistor, maximum of both, or their average.
// - Sleep is never entered while the sleep bit is 0 and is entered on normal conditions when it is 1.
// - The cell count field gives 2, 3 or 4 series cells, with 00 reserved.
// - The LED count field gives 3, 4 or 5 LEDs, with 00 selecting the user display format.
// - The display shows relative charge when the mode bit is 0 and absolute charge when it is 1.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "oca_consts.svh"
`default_nettype none

module oca_config_a #(
    parameter int TEMP_W = 16
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // APB slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Stored configuration path
    input  wire logic              cfgLoadValid,
    input  wire logic [15:0]       cfgLoadData,
    // Device conditions
    input  wire logic              sleepEntryOk,
    input  wire logic              prechargeRequest,
    input  wire logic [TEMP_W-1:0] tempInternal,
    input  wire logic [TEMP_W-1:0] tempExtOne,
    input  wire logic [TEMP_W-1:0] tempExtTwo,
    // Decoded selections
    output logic                   configValid,
    output logic                   zeroVoltFetOn,
    output logic                   chargeFetPrecharge,
    output logic                   altDriveOn,
    output logic                   displaySerial,
    output logic                   displayAbsolute,
    output logic                   displayWhileCharging,
    output logic                   displayOnCapacityAlarm,
    output logic                   displayOnResetExit,
    output logic                   sleepEnter,
    output logic      [2:0]        cellCount,
    output logic                   cellCountReserved,
    output logic      [2:0]        ledCount,
    output logic                   ledUserFormat,
    output logic      [TEMP_W-1:0] reportedTemp
);
    import oca_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] ocaCount(input logic [1:0] field, input logic [2:0] base);
        ocaCount = (field == 2'h0) ? 3'h0 : base + {1'b0, field};
    endfunction : ocaCount

    function automatic logic ocaMapped(input logic [7:0] addr);
        ocaMapped = (addr == `OCA_ADDR_CFG_A) || (addr == `OCA_ADDR_STATUS) || (addr == `OCA_ADDR_TEMP);
    endfunction : ocaMapped

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    oca_state_type     state_reg;
    logic [15:0]       cfg_reg;
    logic [31:0]       rdata_reg;
    logic              ready_reg;
    logic              err_reg;
    logic              valid_reg;
    logic              zvFet_reg;
    logic              chgPre_reg;
    logic              altDrive_reg;
    logic              serial_reg;
    logic              absolute_reg;
    logic              dispChg_reg;
    logic              dispAlarm_reg;
    logic              dispReset_reg;
    logic              sleep_reg;
    logic [2:0]        cells_reg;
    logic              cellsRsvd_reg;
    logic [2:0]        leds_reg;
    logic              ledUser_reg;
    logic [TEMP_W-1:0] temp_reg;

    logic              busWrite;
    logic              cfgWrite;
    logic [15:0]       cfg_next;
    logic              running;
    oca_precharge_type preSel;
    oca_temp_src_type  tempSrc;
    logic [TEMP_W-1:0] tempSelected;
    logic [31:0]       statusWord;

    assign busWrite = psel && penable && ready_reg && pwrite && (paddr == `OCA_ADDR_CFG_A);
    assign cfgWrite = busWrite || cfgLoadValid;
    // A bus write in the same cycle as a stored load wins; it is the later intent.
    assign cfg_next = busWrite ? pwdata[15:0] : cfgLoadData;
    assign running  = (state_reg == OCA_ST_RUN);
    assign preSel   = oca_precharge_type'(cfg_reg[`OCA_PRE_SEL_LSB +: 2]);
    assign tempSrc  = oca_temp_src_type'(cfg_reg[`OCA_TEMP_SRC_LSB +: 2]);

    // ----------------------------------------------------------------
    // Configuration word and start-up sequence
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            cfg_reg <= `OCA_CFG_A_RESET;
        else if (cfgWrite)
            cfg_reg <= cfg_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            state_reg <= OCA_ST_WAIT;
        else
        begin
            case (state_reg)
                OCA_ST_WAIT: if (cfgWrite) state_reg <= OCA_ST_RUN;
                OCA_ST_RUN:  state_reg <= OCA_ST_RUN;
                default:     state_reg <= OCA_ST_WAIT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Reserved bits are only reported; the decoder never looks at them.
    assign statusWord = {28'h0,
                         (cfg_reg[`OCA_LED_CNT_LSB +: 2] == 2'h0),
                         (cfg_reg[`OCA_CELL_CNT_LSB +: 2] == 2'h0),
                         (cfg_reg[`OCA_RSVD_LSB +: 2] != 2'h0),
                         running};

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            // Registered answer: pready rises in the first access cycle.
            ready_reg <= psel && !penable;
            err_reg   <= psel && !penable && !ocaMapped(paddr);
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `OCA_ADDR_CFG_A:  rdata_reg <= {16'h0, cfg_reg};
                    `OCA_ADDR_STATUS: rdata_reg <= statusWord;
                    `OCA_ADDR_TEMP:   rdata_reg <= {{(32-TEMP_W){1'b0}}, temp_reg};
                    default:          rdata_reg <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoded selections
    // ----------------------------------------------------------------
    // Until a word has been applied every selection sits at its safe value.
    always_ff @(posedge core_clk)
    begin
        if (!nrst || !running)
        begin
            zvFet_reg    <= 1'b0;
            chgPre_reg   <= 1'b0;
            altDrive_reg <= 1'b0;
        end
        else
        begin
            zvFet_reg    <= prechargeRequest && (preSel == OCA_PRE_ZERO_VOLT);
            chgPre_reg   <= prechargeRequest && (preSel == OCA_PRE_CHARGE);
            altDrive_reg <= prechargeRequest && (preSel == OCA_PRE_ALT_DRIVE);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst || !running)
        begin
            serial_reg    <= 1'b0;
            absolute_reg  <= 1'b0;
            dispChg_reg   <= 1'b0;
            dispAlarm_reg <= 1'b0;
            dispReset_reg <= 1'b0;
        end
        else
        begin
            serial_reg    <= cfg_reg[`OCA_DISP_IF_BIT];
            absolute_reg  <= cfg_reg[`OCA_SOC_MODE_BIT];
            dispChg_reg   <= cfg_reg[`OCA_DISP_CHG_BIT];
            dispAlarm_reg <= cfg_reg[`OCA_DISP_ALARM_BIT];
            dispReset_reg <= cfg_reg[`OCA_DISP_RESET_BIT];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst || !running)
            sleep_reg <= 1'b0;
        else
            sleep_reg <= cfg_reg[`OCA_SLEEP_BIT] && sleepEntryOk;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst || !running)
        begin
            cells_reg     <= 3'h0;
            cellsRsvd_reg <= 1'b0;
            leds_reg      <= 3'h0;
            ledUser_reg   <= 1'b0;
        end
        else
        begin
            cells_reg     <= ocaCount(cfg_reg[`OCA_CELL_CNT_LSB +: 2], `OCA_CELL_BASE);
            cellsRsvd_reg <= (cfg_reg[`OCA_CELL_CNT_LSB +: 2] == 2'h0);
            leds_reg      <= ocaCount(cfg_reg[`OCA_LED_CNT_LSB +: 2], `OCA_LED_BASE);
            ledUser_reg   <= (cfg_reg[`OCA_LED_CNT_LSB +: 2] == 2'h0);
        end
    end

    oca_temp_select #(
        .TEMP_W       (TEMP_W)
    ) u_temp_select (
        .tempSrc      (tempSrc),
        .tempInternal (tempInternal),
        .tempExtOne   (tempExtOne),
        .tempExtTwo   (tempExtTwo),
        .tempSelected (tempSelected)
    );

    // Before a word is applied the internal sensor is the only trusted source.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            temp_reg <= '0;
        else
            temp_reg <= running ? tempSelected : tempInternal;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            valid_reg <= 1'b0;
        else
            valid_reg <= running;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata                 = rdata_reg;
    assign pready                 = ready_reg;
    assign pslverr                = err_reg;
    assign configValid            = valid_reg;
    assign zeroVoltFetOn          = zvFet_reg;
    assign chargeFetPrecharge     = chgPre_reg;
    assign altDriveOn             = altDrive_reg;
    assign displaySerial          = serial_reg;
    assign displayAbsolute        = absolute_reg;
    assign displayWhileCharging   = dispChg_reg;
    assign displayOnCapacityAlarm = dispAlarm_reg;
    assign displayOnResetExit     = dispReset_reg;
    assign sleepEnter             = sleep_reg;
    assign cellCount              = cells_reg;
    assign cellCountReserved      = cellsRsvd_reg;
    assign ledCount               = leds_reg;
    assign ledUserFormat          = ledUser_reg;
    assign reportedTemp           = temp_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic [TEMP_W:0] avgSum;
    assign avgSum = {1'b0, tempExtOne} + {1'b0, tempExtTwo};

    a_precharge_zero: assert property (running && prechargeRequest && cfg_reg[1:0] == 2'h0
        |=> zvFet_reg && !chgPre_reg && !altDrive_reg)
        else $error("zero-volt FET not chosen");
    a_precharge_none: assert property (cfg_reg[1:0] == 2'h3
        |=> !zvFet_reg && !chgPre_reg && !altDrive_reg)
        else $error("precharge drive active on no-action code");
    a_display_iface: assert property (running |=> serial_reg == $past(cfg_reg[2]))
        else $error("display interface mismatch");
    a_temp_average: assert property (running && cfg_reg[4:3] == 2'h3
        |=> temp_reg == $past(avgSum[TEMP_W:1]))
        else $error("average temperature wrong");
    a_sleep_forbid: assert property (sleep_reg |-> $past(cfg_reg[5]) && $past(sleepEntryOk) && $past(running))
        else $error("sleep entered without permission");
    a_sleep_enter: assert property (running && cfg_reg[5] && sleepEntryOk |=> sleep_reg)
        else $error("sleep not entered");
    a_cell_three: assert property (running && cfg_reg[9:8] == 2'h2 |=> cells_reg == 3'h3)
        else $error("cell count not three");
    a_led_five: assert property (running && cfg_reg[11:10] == 2'h3 |=> leds_reg == 3'h5 && !ledUser_reg)
        else $error("LED count not five");
    a_soc_mode: assert property (running ##1 running |-> absolute_reg == $past(cfg_reg[12]))
        else $error("display mode mismatch");
    a_safe_start: assert property (!valid_reg |-> !sleep_reg && cells_reg == 3'h0 && !zvFet_reg)
        else $error("selection active before configuration");
    a_hold_stable: assert property (running && !cfgWrite ##1 !cfgWrite |=> $stable(cells_reg) && $stable(leds_reg))
        else $error("selection changed without a write");

    c_first_load: cover property (!running ##1 running ##1 valid_reg);
    c_sleep_entry: cover property (running && cfg_reg[5] && sleepEntryOk ##1 sleep_reg);
    c_bus_write: cover property (busWrite ##2 valid_reg);
    c_avg_temp: cover property (running && cfg_reg[4:3] == 2'h3 ##1 running);

endmodule : oca_config_a

`default_nettype wire

// ---- core/oca_consts.svh ----
`ifndef OCA_CONSTS_SVH
`define OCA_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OCA_ADDR_CFG_A      8'h00
`define OCA_ADDR_STATUS     8'h04
`define OCA_ADDR_TEMP       8'h08

// ----------------------------------------------------------------
// Configuration word A reset value and field positions
// ----------------------------------------------------------------
`define OCA_CFG_A_RESET     16'h0008
`define OCA_PRE_SEL_LSB     0
`define OCA_DISP_IF_BIT     2
`define OCA_TEMP_SRC_LSB    3
`define OCA_SLEEP_BIT       5
`define OCA_RSVD_LSB        6
`define OCA_CELL_CNT_LSB    8
`define OCA_LED_CNT_LSB     10
`define OCA_SOC_MODE_BIT    12
`define OCA_DISP_CHG_BIT    13
`define OCA_DISP_ALARM_BIT  14
`define OCA_DISP_RESET_BIT  15

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define OCA_ST_VALID_BIT    0
`define OCA_ST_RSVD_BIT     1
`define OCA_ST_CELL_BIT     2
`define OCA_ST_USER_BIT     3

// ----------------------------------------------------------------
// Count decoding bases
// ----------------------------------------------------------------
`define OCA_CELL_BASE       3'h1
`define OCA_LED_BASE        3'h2

`endif

// ---- core/oca_pkg.sv ----
package oca_pkg;

    typedef enum logic [1:0]
    {
        OCA_ST_WAIT = 2'b01,
        OCA_ST_RUN  = 2'b10
    } oca_state_type;

    typedef enum logic [1:0]
    {
        OCA_PRE_ZERO_VOLT = 2'h0,
        OCA_PRE_CHARGE    = 2'h1,
        OCA_PRE_ALT_DRIVE = 2'h2,
        OCA_PRE_NONE      = 2'h3
    } oca_precharge_type;

    typedef enum logic [1:0]
    {
        OCA_TSRC_INTERNAL = 2'h0,
        OCA_TSRC_EXT_ONE  = 2'h1,
        OCA_TSRC_MAXIMUM  = 2'h2,
        OCA_TSRC_AVERAGE  = 2'h3
    } oca_temp_src_type;

endpackage : oca_pkg

// ---- core/oca_temp_select.sv ----
`timescale 1ns/100ps
`default_nettype none

module oca_temp_select #(
    parameter int TEMP_W = 16
) (
    // Source selection
    input  wire oca_pkg::oca_temp_src_type tempSrc,
    // Measured temperatures
    input  wire logic [TEMP_W-1:0]         tempInternal,
    input  wire logic [TEMP_W-1:0]         tempExtOne,
    input  wire logic [TEMP_W-1:0]         tempExtTwo,
    // Selected value
    output logic      [TEMP_W-1:0]         tempSelected
);
    import oca_pkg::*;

    logic [TEMP_W:0] extSum;

    // The sum keeps its carry so the average never wraps.
    assign extSum = {1'b0, tempExtOne} + {1'b0, tempExtTwo};

    always_comb
    begin
        case (tempSrc)
            OCA_TSRC_INTERNAL: tempSelected = tempInternal;
            OCA_TSRC_EXT_ONE:  tempSelected = tempExtOne;
            OCA_TSRC_MAXIMUM:  tempSelected = (tempExtOne > tempExtTwo) ? tempExtOne : tempExtTwo;
            OCA_TSRC_AVERAGE:  tempSelected = extSum[TEMP_W:1];
            default:           tempSelected = tempExtOne;
        endcase
    end

endmodule : oca_temp_select

`default_nettype wire

// ---- testbench/operation_config_a_decoder_tb.sv ----
`timescale 1ns/100ps
`include "oca_consts.svh"
`default_nettype none

module operation_config_a_decoder_tb;
    import oca_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        coreClk;
    logic        nrst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cfgLoadValid;
    logic [15:0] cfgLoadData;
    logic        sleepEntryOk;
    logic        prechargeRequest;
    logic [15:0] tempInternal;
    logic [15:0] tempExtOne;
    logic [15:0] tempExtTwo;
    logic        configValid;
    logic        zeroVoltFetOn;
    logic        chargeFetPrecharge;
    logic        altDriveOn;
    logic        displaySerial;
    logic        displayAbsolute;
    logic        displayWhileCharging;
    logic        displayOnCapacityAlarm;
    logic        displayOnResetExit;
    logic        sleepEnter;
    logic [2:0]  cellCount;
    logic        cellCountReserved;
    logic [2:0]  ledCount;
    logic        ledUserFormat;
    logic [15:0] reportedTemp;
    logic [15:0] cfgM;
    logic [15:0] expTemp;
    logic        validM;
    int          errors;
    int          totalChecks;
    int          seed;

    oca_config_a #(.TEMP_W(16)) dut (
        .core_clk(coreClk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfgLoadValid(cfgLoadValid), .cfgLoadData(cfgLoadData),
        .sleepEntryOk(sleepEntryOk), .prechargeRequest(prechargeRequest),
        .tempInternal(tempInternal), .tempExtOne(tempExtOne), .tempExtTwo(tempExtTwo),
        .configValid(configValid), .zeroVoltFetOn(zeroVoltFetOn),
        .chargeFetPrecharge(chargeFetPrecharge), .altDriveOn(altDriveOn),
        .displaySerial(displaySerial), .displayAbsolute(displayAbsolute),
        .displayWhileCharging(displayWhileCharging), .displayOnCapacityAlarm(displayOnCapacityAlarm),
        .displayOnResetExit(displayOnResetExit), .sleepEnter(sleepEnter),
        .cellCount(cellCount), .cellCountReserved(cellCountReserved),
        .ledCount(ledCount), .ledUserFormat(ledUserFormat), .reportedTemp(reportedTemp)
    );

    initial
    begin
        coreClk = 1'b0;
        forever #2.5 coreClk = ~coreClk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // Status word: empty LED field, empty cell field, reserved bits set, word applied.
    function automatic logic [31:0] status_of(input logic [15:0] c, input logic run);
        status_of = {28'h0, c[11:10] == 2'h0, c[9:8] == 2'h0, c[7:6] != 2'h0, run};
    endfunction : status_of

    // ------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------
    // Signals change only by NBA right after an edge; the extra edge at the end keeps
    // a following setup from assigning psel twice in one time step.
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge coreClk);
        penable <= 1'b1;
        do
        begin
            @(posedge coreClk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: no bus answer", $time);
        end
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge coreClk);
    endtask : apb_xfer

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b0, addr, 32'h0, r, e);
        check(r, exp);
        check(e, expErr);
    endtask : rd

    // ------------------------------------------------------------
    // Reference model of the decoded selections
    // ------------------------------------------------------------
    task automatic check_outputs();
        logic [16:0] s;
        logic [15:0] c;
        logic        v;
        c = cfgM;
        v = validM;
        s = tempExtOne + tempExtTwo;
        case (c[4:3])
            2'h0:    expTemp = tempInternal;
            2'h1:    expTemp = tempExtOne;
            2'h2:    expTemp = (tempExtOne > tempExtTwo) ? tempExtOne : tempExtTwo;
            default: expTemp = s[16:1];
        endcase
        if (!v)
            expTemp = tempInternal;
        check(configValid, v);
        check({zeroVoltFetOn, chargeFetPrecharge, altDriveOn}, (v && prechargeRequest) ? 3'h4 >> c[1:0] : 3'h0);
        check(displaySerial, v & c[2]);
        check(reportedTemp, expTemp);
        check(sleepEnter, v & c[5] & sleepEntryOk);
        check({cellCountReserved, cellCount}, !v ? 4'h0 : (c[9:8] == 2'h0) ? 4'h8 : {2'h0, c[9:8]} + 4'h1);
        check({ledUserFormat, ledCount}, !v ? 4'h0 : (c[11:10] == 2'h0) ? 4'h8 : {2'h0, c[11:10]} + 4'h2);
        check(displayAbsolute, v & c[12]);
        check({displayWhileCharging, displayOnCapacityAlarm, displayOnResetExit}, v ? {c[13], c[14], c[15]} : 3'h0);
    endtask : check_outputs

    task automatic apply(input logic [15:0] w, input logic viaLoad);
        logic [31:0] r;
        logic        e;
        sleepEntryOk     <= 1'($random(seed));
        prechargeRequest <= 1'($random(seed));
        tempInternal     <= 16'($random(seed)) & 16'h7FFF;
        tempExtOne       <= 16'($random(seed)) & 16'h7FFF;
        tempExtTwo       <= 16'($random(seed)) & 16'h7FFF;
        if (viaLoad)
        begin
            cfgLoadValid <= 1'b1;
            cfgLoadData  <= w;
            @(posedge coreClk);
            cfgLoadValid <= 1'b0;
            repeat (2) @(posedge coreClk);
        end
        else
        begin
            apb_xfer(1'b1, `OCA_ADDR_CFG_A, {16'h0, w}, r, e);
            check(e, 1'b0);
            @(posedge coreClk);
        end
        cfgM   = w;
        validM = 1'b1;
        repeat (3)
        begin
            check_outputs();
            @(posedge coreClk);
        end
        rd(`OCA_ADDR_CFG_A, {16'h0, w}, 1'b0);
        rd(`OCA_ADDR_STATUS, status_of(w, 1'b1), 1'b0);
        rd(`OCA_ADDR_TEMP, {16'h0, expTemp}, 1'b0);
    endtask : apply

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (16) @(posedge coreClk);
        nrst   <= 1'b1;
        cfgM   = `OCA_CFG_A_RESET;
        validM = 1'b0;
        repeat (2) @(posedge coreClk);
        check_outputs();
        rd(`OCA_ADDR_CFG_A, {16'h0, `OCA_CFG_A_RESET}, 1'b0);
        rd(`OCA_ADDR_STATUS, status_of(cfgM, 1'b0), 1'b0);
    endtask : do_reset

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        logic        e;
        logic [15:0] w;
        errors = 0;
        totalChecks = 0;
        seed = 60;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cfgLoadValid = 1'b0;
        cfgLoadData = 16'h0;
        sleepEntryOk = 1'b1;
        prechargeRequest = 1'b1;
        tempInternal = 16'h0123;
        tempExtOne = 16'h0456;
        tempExtTwo = 16'h0789;
        cfgM = `OCA_CFG_A_RESET;
        validM = 1'b0;
        @(posedge coreClk);
        do_reset();
        apb_xfer(1'b1, 8'h0C, 32'hFFFF_FFFF, r, e);
        check(e, 1'b1);
        rd(8'h0C, 32'h0, 1'b1);
        apb_xfer(1'b1, `OCA_ADDR_STATUS, 32'h0000_FFFF, r, e);
        check(e, 1'b0);
        rd(`OCA_ADDR_STATUS, status_of(cfgM, 1'b0), 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            w = 16'($random(seed));
            w = (w & 16'hF024) | {4'h0, i[1:0], i[1:0], 3'h0, i[1:0], 1'b0, i[1:0]};
            apply(w, i[0]);
        end
        for (int i = 0; i < 24; i++)
        begin
            w = 16'($random(seed));
            apply(w & 16'hFF3F, i[0]);
        end
        do_reset();
        apply(16'h5A2D, 1'b0);
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge coreClk);
        errors++;
        $display("Error at %0t: run did not finish", $time);
        summarize();
    end

endmodule : operation_config_a_decoder_tb

`default_nettype wire
